// ---- pkg/ubc_pkg.sv ----
// Constants and types shared by the serial baud and frame configuration.
// Assumes an AHB-Lite master issuing single word transfers.
`default_nettype none
package ubc_pkg;

	// Register byte offsets, one aligned word each.
	localparam logic [7:0] ADDR_BDH   = 8'h00;
	localparam logic [7:0] ADDR_BDL   = 8'h04;
	localparam logic [7:0] ADDR_CTL1  = 8'h08;
	localparam logic [7:0] ADDR_CTL2  = 8'h0c;
	localparam logic [7:0] ADDR_STATE = 8'h10;
	localparam logic [7:0] ADDR_ISTAT = 8'h14;
	localparam logic [7:0] ADDR_IMASK = 8'h18;
	localparam logic [7:0] ADDR_DATA  = 8'h1c;

	// Reset values; the low divisor byte is non-zero.
	localparam logic [4:0] BDH_RST  = 5'h00;
	localparam logic [7:0] BDL_RST  = 8'h04;
	localparam logic [7:0] CTL1_RST = 8'h00;

	// Second control register fields.
	localparam int CTL2_TX_ON  = 3;
	localparam int CTL2_RX_ON  = 2;
	localparam int CTL2_DIR    = 0;
	localparam logic [7:0] CTL2_MASK = 8'h0d;

	// Interrupt status bits.
	localparam int EV_DIV  = 0;
	localparam int EV_RX   = 1;
	localparam int EV_PERR = 2;
	localparam int EV_W    = 3;

	localparam int DIV_W     = 13;
	localparam int OVERSAMP  = 16;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0] HSIZE_WORD    = 3'h2;

	// First control register, bit 7 down to bit 0.
	typedef struct packed {
		logic loopback_select;
		logic freeze_in_wait;
		logic rx_source_select;
		logic nine_bit;
		logic wake_addr_mark;
		logic idle_count_start;
		logic parity_enable;
		logic parity_odd_select;
	} ubc_ctl1_t;

	typedef enum logic [1:0] {
		BUS_IDLE = 2'b00,
		BUS_WR   = 2'b01,
		BUS_RDW  = 2'b10,
		BUS_RDD  = 2'b11
	} ubc_bus_t;

endpackage
`default_nettype wire

// ---- design/ubc_top.sv ----
// Baud divisor, frame configuration and pin routing of a serial port.
// Assumes an AHB-Lite master, a transmit and receive datapath beside it,
// and a pad that resolves the transmit pin from its active-low enable.
//
// How it works
// - High divisor part buffered until low byte written.
// - Divisor zero stops the baud generator.
// - Generator idle until first transmit or receive enable.
// - Loop select joins transmitter to receiver internally.
// - Source bit ignored unless loop select set.
// - Loop and source both set give single wire.
// - Freeze bit stops clocks during CPU wait.
// - Length bit selects eight or nine data bits.
// - Wakeup bit picks idle line or address mark.
// - Idle type picks count start after start/stop.
// - Parity enable makes top data bit parity.
// - Parity type selects even or odd ones count.
// - Eight word-spaced registers of up to nine bits cover baud, options, status, data.
// - Five high divisor bits, eight low bits.
// - Transmitter works and drives pin only when enabled.
// - Direction bit steers the single shared line.
// - Internal loopback releases the transmit pin.
`timescale 1ns/1ns
`default_nettype none
module ubc_top #(
	parameter int OVERSAMPLE = ubc_pkg::OVERSAMP
) (
	input  wire logic              hclk,
	input  wire logic              hresetn,
	input  wire logic              hsel,
	input  wire logic [31:0]       haddr,
	input  wire logic [1:0]        htrans,
	input  wire logic              hwrite,
	input  wire logic [2:0]        hsize,
	input  wire logic [31:0]       hwdata,
	input  wire logic              hready,
	output logic      [31:0]       hrdata,
	output logic                   hreadyout,
	output logic                   hresp,
	input  wire logic              cpu_wait,
	input  wire logic              tx_serial_out,
	input  wire logic              rx_pin,
	input  wire logic              tx_pin_in,
	input  wire logic              rx_char_valid,
	input  wire logic [8:0]        rx_char,
	output logic                   rx_serial_in,
	output logic                   tx_pin_out,
	output logic                   tx_pin_oe_n,
	output ubc_pkg::ubc_ctl1_t     frame_cfg,
	output logic                   tx_on,
	output logic                   rx_on,
	output logic                   module_clk_en,
	output logic                   baud_tick,
	output logic                   bit_tick,
	output logic      [8:0]        tx_char,
	output logic                   tx_char_valid,
	output logic                   irq
);

	localparam int SUB_W = $clog2(OVERSAMPLE);
	localparam logic [SUB_W-1:0] SUB_LAST = SUB_W'(OVERSAMPLE - 1);
	localparam int DW = ubc_pkg::DIV_W;
	localparam int EW = ubc_pkg::EV_W;

	// The bit tick is a simple wrap of the sub-counter.
	if (OVERSAMPLE < 2 || (OVERSAMPLE & (OVERSAMPLE - 1)) != 0)
	begin : g_bad_os
		$error("OVERSAMPLE must be a power of two of at least 2.");
	end

	////////////////////////////////////////////////////////////////////
	// State.

	ubc_pkg::ubc_bus_t    bus_r,       bus_nxt;
	logic [7:0]           addr_r,      addr_nxt;
	logic                 hit_r,       hit_nxt;
	logic                 wok_r,       wok_nxt;
	logic [31:0]          hrdata_r,    hrdata_nxt;
	logic [4:0]           bdh_buf_r,   bdh_buf_nxt;
	logic [DW-1:0]        div_r,       div_nxt;
	ubc_pkg::ubc_ctl1_t   ctl1_r,      ctl1_nxt;
	logic [7:0]           ctl2_r,      ctl2_nxt;
	logic                 started_r,   started_nxt;
	logic [DW-1:0]        cnt_r,       cnt_nxt;
	logic [SUB_W-1:0]     sub_r,       sub_nxt;
	logic                 btick_r,     btick_nxt;
	logic                 bitt_r,      bitt_nxt;
	logic [EW-1:0]        istat_r,     istat_nxt;
	logic [EW-1:0]        imask_r,     imask_nxt;
	logic [8:0]           txc_r,       txc_nxt;
	logic                 txv_r,       txv_nxt;
	logic [8:0]           rxh_r,       rxh_nxt;
	logic                 rxs_r,       rxs_nxt;
	logic                 pin_r,       pin_nxt;
	logic                 oen_r,       oen_nxt;

	logic                 clk_run;
	logic                 gen_run;
	logic                 wr;
	logic [EW-1:0]        ev;
	logic [EW-1:0]        clr;
	logic [7:0]           wb;
	logic                 par;
	logic                 drive;

	////////////////////////////////////////////////////////////////////
	// Read multiplexer; unmapped offsets read as zero.

	function automatic logic [31:0] rd_word(input logic [7:0] a);
		logic [31:0] w;
		w = '0;
		case (a)
			ubc_pkg::ADDR_BDH:   w[4:0] = bdh_buf_r;
			ubc_pkg::ADDR_BDL:   w[7:0] = div_r[7:0];
			ubc_pkg::ADDR_CTL1:  w[7:0] = ctl1_r;
			ubc_pkg::ADDR_CTL2:  w[7:0] = ctl2_r;
			ubc_pkg::ADDR_STATE:
			begin
				w[0] = gen_run;
				w[1] = started_r;
				w[2] = ~oen_r;
				w[3] = clk_run;
			end
			ubc_pkg::ADDR_ISTAT: w[EW-1:0] = istat_r;
			ubc_pkg::ADDR_IMASK: w[EW-1:0] = imask_r;
			ubc_pkg::ADDR_DATA:  w[8:0] = rxh_r;
			default:             w = '0;
		endcase
		return w;
	endfunction

	////////////////////////////////////////////////////////////////////
	// Next-state logic.

	always_comb
	begin
		bus_nxt     = bus_r;
		addr_nxt    = addr_r;
		hit_nxt     = hit_r;
		wok_nxt     = wok_r;
		hrdata_nxt  = hrdata_r;
		bdh_buf_nxt = bdh_buf_r;
		div_nxt     = div_r;
		ctl1_nxt    = ctl1_r;
		ctl2_nxt    = ctl2_r;
		started_nxt = started_r;
		cnt_nxt     = cnt_r;
		sub_nxt     = sub_r;
		btick_nxt   = 1'b0;
		bitt_nxt    = 1'b0;
		imask_nxt   = imask_r;
		txc_nxt     = txc_r;
		txv_nxt     = 1'b0;
		rxh_nxt     = rxh_r;
		ev          = '0;
		clr         = '0;
		wb          = hwdata[7:0];
		par         = 1'b0;

		// Wait-mode freeze of the module clocks.
		clk_run = ~(cpu_wait & ctl1_r.freeze_in_wait);
		gen_run = started_r && (div_r != '0) && clk_run;

		// Bus: writes complete with no wait state, reads take one.
		wr = (bus_r == ubc_pkg::BUS_WR) && hit_r && wok_r;
		case (bus_r)
			ubc_pkg::BUS_RDW:
			begin
				hrdata_nxt = hit_r ? rd_word(addr_r) : '0;
				bus_nxt = ubc_pkg::BUS_RDD;
			end
			default:
			begin
				bus_nxt = ubc_pkg::BUS_IDLE;
				if (hsel && hready && htrans == ubc_pkg::HTRANS_NONSEQ)
				begin
					addr_nxt = haddr[7:0];
					hit_nxt  = (haddr[31:8] == '0) && (haddr[1:0] == '0);
					wok_nxt  = (hsize == ubc_pkg::HSIZE_WORD);
					bus_nxt  = hwrite ? ubc_pkg::BUS_WR
					                  : ubc_pkg::BUS_RDW;
				end
			end
		endcase

		// Register writes.
		if (wr)
		begin
			case (addr_r)
				ubc_pkg::ADDR_BDH: bdh_buf_nxt = wb[4:0];
				ubc_pkg::ADDR_BDL:
				begin
					div_nxt = {bdh_buf_r, wb};
					cnt_nxt = '0;
					sub_nxt = '0;
					ev[ubc_pkg::EV_DIV] = 1'b1;
				end
				ubc_pkg::ADDR_CTL1: ctl1_nxt = ubc_pkg::ubc_ctl1_t'(wb);
				ubc_pkg::ADDR_CTL2:
				begin
					ctl2_nxt = wb & ubc_pkg::CTL2_MASK;
					if (wb[ubc_pkg::CTL2_TX_ON] || wb[ubc_pkg::CTL2_RX_ON])
						started_nxt = 1'b1;
				end
				ubc_pkg::ADDR_ISTAT: clr = wb[EW-1:0];
				ubc_pkg::ADDR_IMASK: imask_nxt = wb[EW-1:0];
				ubc_pkg::ADDR_DATA:
				begin
					txc_nxt = {hwdata[8], wb};
					// Parity replaces the top data bit of the character.
					if (ctl1_r.parity_enable)
					begin
						if (ctl1_r.nine_bit)
							txc_nxt[8] = ^wb ^ ctl1_r.parity_odd_select;
						else
							txc_nxt[7] = ^wb[6:0]
							             ^ ctl1_r.parity_odd_select;
					end
					if (!ctl1_r.nine_bit)
						txc_nxt[8] = 1'b0;
					txv_nxt = ctl2_r[ubc_pkg::CTL2_TX_ON];
				end
				default: ;
			endcase
		end

		// Baud generator: divide by the divisor, then by the oversample.
		if (!gen_run)
		begin
			cnt_nxt = '0;
			sub_nxt = '0;
		end
		else if (!(wr && addr_r == ubc_pkg::ADDR_BDL))
		begin
			if (cnt_r == div_r - DW'(1))
			begin
				cnt_nxt   = '0;
				btick_nxt = 1'b1;
				sub_nxt   = sub_r + SUB_W'(1);
				bitt_nxt  = (sub_r == SUB_LAST);
			end
			else
				cnt_nxt = cnt_r + DW'(1);
		end

		// Received character parity check while the clocks run.
		if (rx_char_valid && clk_run && ctl2_r[ubc_pkg::CTL2_RX_ON])
		begin
			rxh_nxt = rx_char;
			ev[ubc_pkg::EV_RX] = 1'b1;
			par = ctl1_r.nine_bit ? ^rx_char : ^rx_char[7:0];
			if (ctl1_r.parity_enable && par != ctl1_r.parity_odd_select)
				ev[ubc_pkg::EV_PERR] = 1'b1;
		end

		// A new event wins over a clear in the same cycle.
		istat_nxt = (istat_r & ~clr) | ev;

		// Pin routing.
		drive   = 1'b0;
		rxs_nxt = rx_pin;
		if (!ctl1_r.loopback_select)
			drive = ctl2_r[ubc_pkg::CTL2_TX_ON];
		else if (!ctl1_r.rx_source_select)
			rxs_nxt = tx_serial_out;
		else
		begin
			drive = ctl2_r[ubc_pkg::CTL2_TX_ON]
			        & ctl2_r[ubc_pkg::CTL2_DIR];
			rxs_nxt = ctl2_r[ubc_pkg::CTL2_DIR] ? tx_serial_out
			                                    : tx_pin_in;
		end
		pin_nxt = tx_serial_out;
		oen_nxt = ~drive;
	end

	////////////////////////////////////////////////////////////////////
	// Registers.

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			bus_r     <= ubc_pkg::BUS_IDLE;
			addr_r    <= '0;
			hit_r     <= 1'b0;
			wok_r     <= 1'b0;
			hrdata_r  <= '0;
			bdh_buf_r <= ubc_pkg::BDH_RST;
			div_r     <= {ubc_pkg::BDH_RST, ubc_pkg::BDL_RST};
			ctl1_r    <= ubc_pkg::ubc_ctl1_t'(ubc_pkg::CTL1_RST);
			ctl2_r    <= '0;
			started_r <= 1'b0;
			cnt_r     <= '0;
			sub_r     <= '0;
			btick_r   <= 1'b0;
			bitt_r    <= 1'b0;
			istat_r   <= '0;
			imask_r   <= '0;
			txc_r     <= '0;
			txv_r     <= 1'b0;
			rxh_r     <= '0;
			rxs_r     <= 1'b1;
			pin_r     <= 1'b1;
			oen_r     <= 1'b1;
		end
		else
		begin
			bus_r     <= bus_nxt;
			addr_r    <= addr_nxt;
			hit_r     <= hit_nxt;
			wok_r     <= wok_nxt;
			hrdata_r  <= hrdata_nxt;
			bdh_buf_r <= bdh_buf_nxt;
			div_r     <= div_nxt;
			ctl1_r    <= ctl1_nxt;
			ctl2_r    <= ctl2_nxt;
			started_r <= started_nxt;
			cnt_r     <= cnt_nxt;
			sub_r     <= sub_nxt;
			btick_r   <= btick_nxt;
			bitt_r    <= bitt_nxt;
			istat_r   <= istat_nxt;
			imask_r   <= imask_nxt;
			txc_r     <= txc_nxt;
			txv_r     <= txv_nxt;
			rxh_r     <= rxh_nxt;
			rxs_r     <= rxs_nxt;
			pin_r     <= pin_nxt;
			oen_r     <= oen_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Outputs.

	assign hrdata        = hrdata_r;
	assign hreadyout     = (bus_r != ubc_pkg::BUS_RDW);
	assign hresp         = 1'b0;
	assign rx_serial_in  = rxs_r;
	assign tx_pin_out    = pin_r;
	assign tx_pin_oe_n   = oen_r;
	assign frame_cfg     = ctl1_r;
	assign tx_on         = ctl2_r[ubc_pkg::CTL2_TX_ON];
	assign rx_on         = ctl2_r[ubc_pkg::CTL2_RX_ON];
	assign module_clk_en = clk_run;
	assign baud_tick     = btick_r;
	assign bit_tick      = bitt_r;
	assign tx_char       = txc_r;
	assign tx_char_valid = txv_r;
	assign irq           = |(istat_r & imask_r);

endmodule
`default_nettype wire

// ---- testbench/ubc_checker.sv ----
// Port assertions for the serial baud and frame configuration block.
// Assumes one clock domain and an active-low asynchronous reset.
`timescale 1ns/1ns
`default_nettype none
module ubc_checker #(
	parameter int OVERSAMPLE = 16
) (
	input wire logic               hclk,
	input wire logic               hresetn,
	input wire logic               hsel,
	input wire logic [1:0]         htrans,
	input wire logic               hwrite,
	input wire logic               hreadyout,
	input wire logic               hresp,
	input wire logic               cpu_wait,
	input wire logic               tx_serial_out,
	input wire logic               rx_pin,
	input wire logic               rx_serial_in,
	input wire logic               tx_pin_oe_n,
	input wire ubc_pkg::ubc_ctl1_t frame_cfg,
	input wire logic               tx_on,
	input wire logic               module_clk_en,
	input wire logic               baud_tick,
	input wire logic               bit_tick,
	input wire logic [8:0]         tx_char,
	input wire logic               tx_char_valid
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	wire logic lp  = frame_cfg.loopback_select;
	wire logic src = frame_cfg.rx_source_select;
	wire logic nb  = frame_cfg.nine_bit;
	wire logic pe  = frame_cfg.parity_enable;
	wire logic od  = frame_cfg.parity_odd_select;
	wire logic acc = hsel && hreadyout && htrans == ubc_pkg::HTRANS_NONSEQ;
	////////////////////////////////////////
	okay_resp_a: assert property (hresp == 1'h0)
		else $error("response not okay");
	read_wait_a: assert property (acc && !hwrite |=> !hreadyout ##1 hreadyout)
		else $error("read wait state wrong");
	write_fast_a: assert property (acc && hwrite |=> hreadyout)
		else $error("write stalled");
	wait_gate_a: assert property (module_clk_en == !(cpu_wait && frame_cfg.freeze_in_wait))
		else $error("clock enable wrong");
	wait_freeze_a: assert property ($past(!module_clk_en) |-> !baud_tick)
		else $error("tick while frozen");
	bit_in_baud_a: assert property (bit_tick |-> baud_tick)
		else $error("bit tick alone");
	loop_route_a: assert property (lp && !src |=> tx_pin_oe_n && rx_serial_in == $past(tx_serial_out))
		else $error("loopback routing wrong");
	split_route_a: assert property (!lp |=> rx_serial_in == $past(rx_pin) && tx_pin_oe_n == !$past(tx_on))
		else $error("two pin routing wrong");
	eight_bit_a: assert property (tx_char_valid && !nb |-> !tx_char[8])
		else $error("ninth bit in eight bit mode");
	par_eight_a: assert property (tx_char_valid && pe && !nb |-> (^tx_char[7:0]) == od)
		else $error("eight bit parity wrong");
	par_nine_a: assert property (tx_char_valid && pe && nb |-> (^tx_char) == od)
		else $error("nine bit parity wrong");
	cover property (bit_tick);
	cover property (lp && src && !tx_pin_oe_n);
	cover property (tx_char_valid && pe && nb);
endmodule
bind ubc_top ubc_checker #(.OVERSAMPLE(OVERSAMPLE)) i_chk (.hclk, .hresetn,
	.hsel, .htrans, .hwrite, .hreadyout, .hresp, .cpu_wait, .tx_serial_out,
	.rx_pin, .rx_serial_in, .tx_pin_oe_n, .frame_cfg, .tx_on, .module_clk_en,
	.baud_tick, .bit_tick, .tx_char, .tx_char_valid);
`default_nettype wire

// ---- testbench/ubc_remote_port.sv ----
// Remote serial port standing on the line side of the block.
// Assumes a pad that lets the block's driver win while it is enabled.
`timescale 1ns/1ns
`default_nettype none
module ubc_remote_port (
	input  wire logic send_level,
	input  wire logic tx_pin_out,
	input  wire logic tx_pin_oe_n,
	output logic      rx_pin,
	output logic      tx_pin_in
);
	assign rx_pin = send_level;
	// The remote speaks on the shared wire only while the block lets go.
	assign tx_pin_in = tx_pin_oe_n ? send_level : tx_pin_out;
endmodule
`default_nettype wire

// ---- testbench/tb.sv ----
// Self-checking bench for the serial baud and frame configuration.
// Assumes one AHB-Lite slave whose hreadyout is the bus hready.
`timescale 1ns/1ns
`default_nettype none
module tb;
	logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, cpu_wait = 0;
	logic        tx_serial_out = 1, send_level = 1, rx_char_valid = 0;
	logic [1:0]  htrans = 0;
	logic [8:0]  rx_char = 0, tx_char, e;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, got;
	logic        hreadyout, hresp, rx_pin, tx_pin_in, rx_serial_in;
	logic        tx_pin_out, tx_pin_oe_n, tx_on, rx_on, module_clk_en;
	logic        baud_tick, bit_tick, tx_char_valid, irq;
	logic [7:0]  c;
	ubc_pkg::ubc_ctl1_t frame_cfg;
	int          miscompares = 0, compares = 0, cyc = 0;
	logic [23:0] rt [6] = '{24'h000c00, 24'h800c11, 24'ha00c10,
		24'ha00d01, 24'h200c00, 24'h000010};
	logic [7:0]  pt [6] = '{8'h00, 8'h02, 8'h03, 8'h12, 8'h13, 8'h1c};
	ubc_top i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
		.hsize(ubc_pkg::HSIZE_WORD), .hwdata, .hready(hreadyout), .hrdata,
		.hreadyout, .hresp, .cpu_wait, .tx_serial_out, .rx_pin, .tx_pin_in,
		.rx_char_valid, .rx_char, .rx_serial_in, .tx_pin_out, .tx_pin_oe_n,
		.frame_cfg, .tx_on, .rx_on, .module_clk_en, .baud_tick, .bit_tick,
		.tx_char, .tx_char_valid, .irq);
	ubc_remote_port i_far (.send_level, .tx_pin_out, .tx_pin_oe_n, .rx_pin,
		.tx_pin_in);
	always #2 hclk = ~hclk;
	////////////////////////////////////////
	task automatic final_report;
		$display("compares=%0d miscompares=%0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	always @(posedge hclk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			miscompares++;
			final_report();
		end
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		compares++;
		if (g !== x)
		begin
			miscompares++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, x);
		end
	endtask
	// Waits for hready high at a rising edge, keeping the data seen there.
	task automatic hold(output logic [31:0] q);
		logic r;
		do
		begin
			@(negedge hclk);
			r = hreadyout;
			q = hrdata;
			@(posedge hclk);
		end
		while (r !== 1'h1);
	endtask
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		@(posedge hclk);
		hsel   <= 1'h1;
		haddr  <= {24'h0, a};
		htrans <= ubc_pkg::HTRANS_NONSEQ;
		hwrite <= w;
		hold(q);
		hsel   <= 1'h0;
		htrans <= 2'h0;
		hwdata <= d;
		hold(q);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'h1, a, d, got);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] x);
		xfer(1'h0, a, 32'h0, got);
		chk(got, x);
	endtask
	task automatic ticks(input int n, input int eb, input int et);
		logic [31:0] b, t;
		b = 0;
		t = 0;
		@(posedge hclk);
		repeat (n)
		begin
			@(negedge hclk);
			b += baud_tick;
			t += bit_tick;
		end
		chk(b, eb);
		chk(t, et);
	endtask
	////////////////////////////////////////
	initial
	begin
		repeat (5) @(posedge hclk);
		hresetn <= 1'h1;
		rd(ubc_pkg::ADDR_BDH, 0);
		rd(ubc_pkg::ADDR_BDL, 4);
		rd(ubc_pkg::ADDR_CTL1, 0);
		rd(8'h20, 0);
		ticks(64, 0, 0);
		wr(ubc_pkg::ADDR_BDL, 3);
		wr(ubc_pkg::ADDR_CTL2, 12);
		ticks(96, 32, 2);
		wr(ubc_pkg::ADDR_BDH, 1);
		rd(ubc_pkg::ADDR_BDH, 1);
		ticks(96, 32, 2);
		wr(ubc_pkg::ADDR_BDL, 0);
		ticks(520, 2, 0);
		wr(ubc_pkg::ADDR_BDH, 0);
		wr(ubc_pkg::ADDR_BDL, 0);
		ticks(100, 0, 0);
		rd(ubc_pkg::ADDR_STATE, 32'he);
		wr(ubc_pkg::ADDR_BDL, 3);
		cpu_wait <= 1'h1;
		wr(ubc_pkg::ADDR_CTL1, 8'h40);
		ticks(96, 0, 0);
		wr(ubc_pkg::ADDR_CTL1, 0);
		ticks(96, 32, 2);
		@(posedge hclk);
		cpu_wait <= 1'h0;
		send_level <= 1'h0;
		for (int i = 0; i < 6; i++)
		begin
			wr(ubc_pkg::ADDR_CTL1, rt[i][23:16]);
			wr(ubc_pkg::ADDR_CTL2, rt[i][15:8]);
			repeat (3) @(negedge hclk);
			chk(32'(tx_pin_oe_n), rt[i][4]);
			chk(32'(rx_serial_in), rt[i][0]);
		end
		@(posedge hclk);
		tx_serial_out <= 1'h0;
		repeat (2) @(negedge hclk);
		chk(32'(tx_pin_out), 0);
		chk(32'(rx_on), 0);
		@(posedge hclk);
		tx_serial_out <= 1'h1;
		wr(ubc_pkg::ADDR_CTL2, 12);
		@(negedge hclk);
		chk(32'(rx_on), 1);
		for (int i = 0; i < 6; i++)
		begin
			c = pt[i];
			wr(ubc_pkg::ADDR_CTL1, c);
			rd(ubc_pkg::ADDR_CTL1, c);
			chk(32'(frame_cfg), c);
			e = c[4] ? 9'h1a5 : 9'h0a5;
			if (c[1] && c[4])
				e[8] = ^e[7:0] ^ c[0];
			if (c[1] && !c[4])
				e[7] = ^e[6:0] ^ c[0];
			wr(ubc_pkg::ADDR_DATA, 32'h1a5);
			got = 'x;
			repeat (4)
			begin
				@(negedge hclk);
				if (tx_char_valid === 1'h1)
					got = tx_char;
			end
			chk(got, e);
		end
		wr(ubc_pkg::ADDR_CTL1, 8'h02);
		wr(ubc_pkg::ADDR_ISTAT, 7);
		rx_char <= 9'h031;
		rx_char_valid <= 1'h1;
		@(posedge hclk);
		rx_char_valid <= 1'h0;
		rd(ubc_pkg::ADDR_ISTAT, 6);
		rd(ubc_pkg::ADDR_DATA, 32'h31);
		wr(ubc_pkg::ADDR_IMASK, 2);
		@(negedge hclk);
		chk(32'(irq), 1);
		wr(ubc_pkg::ADDR_IMASK, 0);
		@(negedge hclk);
		chk(32'(irq), 0);
		wr(ubc_pkg::ADDR_ISTAT, 6);
		rd(ubc_pkg::ADDR_ISTAT, 0);
		final_report();
	end
endmodule
`default_nettype wire
